// ### rtl/cfl_pkg.sv
// constants, opcodes and state type for the cpu flag, low-power and break core
package cfl_pkg;
   // =====================================================================
   // condition code bit positions
   localparam int CCR_V = 7;
   localparam int CCR_H = 4;
   localparam int CCR_I = 3;
   localparam int CCR_N = 2;
   localparam int CCR_Z = 1;
   localparam int CCR_C = 0;
   localparam logic [7:0] CCR_FIXED_ONES = 8'h60;
   // =====================================================================
   // reset values
   localparam logic [7:0]  CCR_RESET = 8'h68;
   localparam logic [15:0] SP_RESET  = 16'h00FF;
   localparam logic [15:0] PC_RESET  = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   // =====================================================================
   // vectors (high byte at base, low byte at base plus one)
   localparam logic [15:0] VEC_RESET   = 16'hFFFE;
   localparam logic [15:0] VEC_TRAP    = 16'hFFFC;
   localparam logic [15:0] VEC_TRAP_MON = 16'hFEFC;
   localparam logic [15:0] VEC_IRQ     = 16'hFFFA;
   // =====================================================================
   // opcodes
   localparam logic [7:0] OP_ADC_IMM  = 8'hA9;
   localparam logic [7:0] OP_ADD_IMM  = 8'hAB;
   localparam logic [7:0] OP_AND_IMM  = 8'hA4;
   localparam logic [7:0] OP_SP_ADJ   = 8'hA7;
   localparam logic [7:0] OP_IDX_ADJ  = 8'hAF;
   localparam logic [7:0] OP_BR_NC    = 8'h24;
   localparam logic [7:0] OP_BR_C     = 8'h25;
   localparam logic [7:0] OP_SHL_DIR  = 8'h38;
   localparam logic [7:0] OP_SHL_A    = 8'h48;
   localparam logic [7:0] OP_SHL_X    = 8'h58;
   localparam logic [7:0] OP_SHL_IX1  = 8'h68;
   localparam logic [7:0] OP_SHL_IX   = 8'h78;
   localparam logic [7:0] OP_SHR_DIR  = 8'h37;
   localparam logic [7:0] OP_SHR_A    = 8'h47;
   localparam logic [7:0] OP_SHR_X    = 8'h57;
   localparam logic [7:0] OP_SHR_IX1  = 8'h67;
   localparam logic [7:0] OP_SHR_IX   = 8'h77;
   localparam logic [7:0] OP_PREFIX   = 8'h9E;
   localparam logic [7:0] OP_TRAP     = 8'h83;
   localparam logic [7:0] OP_RET_TRAP = 8'h80;
   localparam logic [7:0] OP_WAIT     = 8'h8F;
   localparam logic [7:0] OP_STOP     = 8'h8E;
   localparam logic [3:0] OP_BITCLR_HI = 4'h1;
   // =====================================================================
   // sequencing counts
   localparam logic [2:0] STACK_LAST_STEP = 3'h4;
   localparam int OSC_STAB_CYCLES = 4096;
   // =====================================================================
   typedef enum logic [3:0] {
      S_FETCH = 4'h0,
      S_OPND  = 4'h1,
      S_RD    = 4'h2,
      S_WR    = 4'h3,
      S_BR    = 4'h4,
      S_PUSH  = 4'h5,
      S_VEC   = 4'h6,
      S_PULL  = 4'h7,
      S_WAIT  = 4'h8,
      S_STOP  = 4'h9,
      S_RECOV = 4'hA
   } cfl_state_e;
endpackage

// ### rtl/cfl_core.sv
// instruction core subset: flags, low-power modes, break entry and first opcodes
// =====================================================================
// Operation
// - zero flag follows all-zero result byte
// - carry set on add carry-out
// - shifts also update carry by their operation
// - wait clears interrupt mask, stops clock
// - wait exit: irq stacks mask clear then sets it, reset sets
// - stop clears mask, stops clock; exits on external pin or reset
// - clock resumes after oscillator stabilisation delay
// - break loads trap opcode and trap vector
// - break taken at instruction end, immediately
// - return in break ends it if released
// - add-carry, add, and into accumulator
// - stack adjust adds signed immediate, two cycles
// - index adjust adds signed immediate, two cycles
// - branch when carry clear, three cycles
// - branch when carry set, three cycles
// - mask set holds off maskable interrupts
`timescale 1ns/1ps
module cfl_core #(
   parameter int OSC_STAB = cfl_pkg::OSC_STAB_CYCLES
) (
   input  wire logic        core_clk,      // bus clock, 40 MHz
   input  wire logic        sys_rst,       // synchronous reset, active high
   output logic [15:0]      mem_addr,      // memory address
   input  wire logic [7:0]  mem_rdata,     // read data, same cycle
   output logic [7:0]       mem_wdata,     // write data
   output logic             mem_we,        // write strobe
   input  wire logic        irq_req,       // internal maskable request
   input  wire logic        ext_irq_pin,   // external request pin, async
   input  wire logic        break_req,     // break match request
   input  wire logic        monitor_mode,  // monitor mode level
   output logic             core_clk_en,   // core clock running
   output logic             break_active,  // break routine in progress
   output logic             int_mask       // interrupt mask bit
);
   // =====================================================================
   // functions
   function automatic logic [8:0] shift_op(input logic [7:0] d, input logic right);
      shift_op = right ? {d[0], d[7], d[7:1]} : {d[7], d[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] set_vnzc(input logic [7:0] c_in, input logic [7:0] r,
                                           input logic v, input logic c);
      logic [7:0] t;
      t = c_in;
      t[cfl_pkg::CCR_V] = v;
      t[cfl_pkg::CCR_N] = r[7];
      t[cfl_pkg::CCR_Z] = (r == cfl_pkg::BYTE_ZERO);
      t[cfl_pkg::CCR_C] = c;
      set_vnzc = t;
   endfunction

   // =====================================================================
   // registers
   cfl_pkg::cfl_state_e st_reg, st_next;
   logic [15:0] pc_reg, pc_next, sp_reg, sp_next, ea_reg, ea_next, vec_reg, vec_next;
   logic [15:0] rec_reg, rec_next;
   logic [7:0]  a_reg, a_next, x_reg, x_next, h_reg, h_next, ccr_reg, ccr_next;
   logic [7:0]  ir_reg, ir_next, res_reg, res_next;
   logic [2:0]  step_reg, step_next;
   logic        spm_reg, spm_next, brk_reg, brk_next;
   logic        s1_reg, s2_reg, s3_reg, ext_lvl_reg;
   logic        fin;

   // =====================================================================
   // decode wires
   wire logic [15:0] rel_sext = {{8{mem_rdata[7]}}, mem_rdata};
   wire logic [15:0] hx       = {h_reg, x_reg};
   wire logic        in_fetch = (st_reg == cfl_pkg::S_FETCH);
   wire logic [7:0]  sh_src   = in_fetch ? (mem_rdata[4] ? x_reg : a_reg) : mem_rdata;
   wire logic        sh_right = in_fetch ? mem_rdata[0] : ir_reg[0];
   wire logic [8:0]  sh_out   = shift_op(sh_src, sh_right);
   wire logic        sh_v     = sh_out[7] ^ sh_out[8];
   wire logic        add_cin  = (ir_reg == cfl_pkg::OP_ADC_IMM) & ccr_reg[cfl_pkg::CCR_C];
   wire logic [8:0]  sum      = {1'b0, a_reg} + {1'b0, mem_rdata} + {8'h00, add_cin};
   wire logic [4:0]  hsum     = {1'b0, a_reg[3:0]} + {1'b0, mem_rdata[3:0]} + {4'h0, add_cin};
   wire logic        add_v    = (a_reg[7] == mem_rdata[7]) & (sum[7] != a_reg[7]);
   wire logic [7:0]  and_res  = a_reg & mem_rdata;
   wire logic        is_bitclr = (ir_reg[7:4] == cfl_pkg::OP_BITCLR_HI) & ir_reg[0];
   wire logic [7:0]  clr_mask = ~(8'h01 << ir_reg[3:1]);
   wire logic        irq_any  = irq_req | ext_lvl_reg;
   wire logic        take_brk = break_req & ~brk_reg;
   wire logic        take_irq = irq_any & ~ccr_reg[cfl_pkg::CCR_I];
   wire logic [15:0] trap_vec = monitor_mode ? cfl_pkg::VEC_TRAP_MON : cfl_pkg::VEC_TRAP;
   wire logic [15:0] rec_last = 16'(OSC_STAB - 1);

   // =====================================================================
   // bus outputs from state and registers
   assign mem_we = (st_reg == cfl_pkg::S_WR) | (st_reg == cfl_pkg::S_PUSH);
   always_comb begin
      case (st_reg)
         cfl_pkg::S_RD, cfl_pkg::S_WR: mem_addr = ea_reg;
         cfl_pkg::S_PUSH:             mem_addr = sp_reg;
         cfl_pkg::S_PULL:             mem_addr = sp_reg + 16'h0001;
         cfl_pkg::S_VEC:              mem_addr = vec_reg + {13'h0000, step_reg};
         default:                     mem_addr = pc_reg;
      endcase
      case (step_reg)
         3'h0:    mem_wdata = (st_reg == cfl_pkg::S_WR) ? res_reg : pc_reg[7:0];
         3'h1:    mem_wdata = pc_reg[15:8];
         3'h2:    mem_wdata = x_reg;
         3'h3:    mem_wdata = a_reg;
         default: mem_wdata = ccr_reg;
      endcase
   end
   assign core_clk_en = (st_reg != cfl_pkg::S_WAIT) & (st_reg != cfl_pkg::S_STOP) &
                        (st_reg != cfl_pkg::S_RECOV);
   assign break_active = brk_reg;
   assign int_mask = ccr_reg[cfl_pkg::CCR_I];

   // =====================================================================
   // sequencer
   always_comb begin
      st_next = st_reg;
      pc_next = pc_reg;
      sp_next = sp_reg;
      ea_next = ea_reg;
      vec_next = vec_reg;
      rec_next = rec_reg;
      a_next = a_reg;
      x_next = x_reg;
      h_next = h_reg;
      ccr_next = ccr_reg;
      ir_next = ir_reg;
      res_next = res_reg;
      step_next = step_reg;
      spm_next = spm_reg;
      brk_next = brk_reg;
      fin = 1'b0;
      case (st_reg)
         cfl_pkg::S_FETCH: begin
            ir_next = mem_rdata;
            pc_next = pc_reg + 16'h0001;
            spm_next = 1'b0;
            st_next = cfl_pkg::S_OPND;
            case (mem_rdata)
               cfl_pkg::OP_SHL_A, cfl_pkg::OP_SHR_A: begin
                  a_next = sh_out[7:0];
                  ccr_next = set_vnzc(ccr_reg, sh_out[7:0], sh_v, sh_out[8]);
                  fin = 1'b1;
               end
               cfl_pkg::OP_SHL_X, cfl_pkg::OP_SHR_X: begin
                  x_next = sh_out[7:0];
                  ccr_next = set_vnzc(ccr_reg, sh_out[7:0], sh_v, sh_out[8]);
                  fin = 1'b1;
               end
               cfl_pkg::OP_WAIT: begin
                  ccr_next[cfl_pkg::CCR_I] = 1'b0;
                  st_next = cfl_pkg::S_WAIT;
               end
               cfl_pkg::OP_STOP: begin
                  ccr_next[cfl_pkg::CCR_I] = 1'b0;
                  st_next = cfl_pkg::S_STOP;
               end
               cfl_pkg::OP_RET_TRAP: begin
                  st_next = cfl_pkg::S_PULL;
                  step_next = 3'h0;
               end
               cfl_pkg::OP_TRAP: begin
                  st_next = cfl_pkg::S_PUSH;
                  step_next = 3'h0;
                  vec_next = cfl_pkg::VEC_TRAP;
               end
               cfl_pkg::OP_SHL_IX, cfl_pkg::OP_SHR_IX: begin
                  ea_next = hx;
                  st_next = cfl_pkg::S_RD;
               end
               default: st_next = cfl_pkg::S_OPND;
            endcase
         end
         cfl_pkg::S_OPND: begin
            pc_next = pc_reg + 16'h0001;
            if (ir_reg == cfl_pkg::OP_PREFIX) begin
               ir_next = mem_rdata;
               spm_next = 1'b1;
            end else begin
               case (ir_reg)
                  cfl_pkg::OP_ADC_IMM, cfl_pkg::OP_ADD_IMM: begin
                     a_next = sum[7:0];
                     ccr_next = set_vnzc(ccr_reg, sum[7:0], add_v, sum[8]);
                     ccr_next[cfl_pkg::CCR_H] = hsum[4];
                     fin = 1'b1;
                  end
                  cfl_pkg::OP_AND_IMM: begin
                     a_next = and_res;
                     ccr_next = set_vnzc(ccr_reg, and_res, 1'b0, ccr_reg[cfl_pkg::CCR_C]);
                     fin = 1'b1;
                  end
                  cfl_pkg::OP_SP_ADJ: begin
                     sp_next = sp_reg + rel_sext;
                     fin = 1'b1;
                  end
                  cfl_pkg::OP_IDX_ADJ: begin
                     {h_next, x_next} = hx + rel_sext;
                     fin = 1'b1;
                  end
                  cfl_pkg::OP_BR_NC, cfl_pkg::OP_BR_C: begin
                     if (ccr_reg[cfl_pkg::CCR_C] == ir_reg[0])
                        pc_next = pc_reg + 16'h0001 + rel_sext;
                     st_next = cfl_pkg::S_BR;
                  end
                  cfl_pkg::OP_SHL_DIR, cfl_pkg::OP_SHR_DIR: begin
                     ea_next = {8'h00, mem_rdata};
                     st_next = cfl_pkg::S_RD;
                  end
                  cfl_pkg::OP_SHL_IX1, cfl_pkg::OP_SHR_IX1: begin
                     ea_next = (spm_reg ? sp_reg : hx) + {8'h00, mem_rdata};
                     st_next = cfl_pkg::S_RD;
                  end
                  default: begin
                     if (is_bitclr) begin
                        ea_next = {8'h00, mem_rdata};
                        st_next = cfl_pkg::S_RD;
                     end else
                        fin = 1'b1;
                  end
               endcase
            end
         end
         cfl_pkg::S_RD: begin
            if (is_bitclr)
               res_next = mem_rdata & clr_mask;
            else begin
               res_next = sh_out[7:0];
               ccr_next = set_vnzc(ccr_reg, sh_out[7:0], sh_v, sh_out[8]);
            end
            step_next = 3'h0;
            st_next = cfl_pkg::S_WR;
         end
         cfl_pkg::S_WR, cfl_pkg::S_BR: fin = 1'b1;
         cfl_pkg::S_PUSH: begin
            sp_next = sp_reg - 16'h0001;
            step_next = step_reg + 3'h1;
            if (step_reg == cfl_pkg::STACK_LAST_STEP) begin
               ccr_next[cfl_pkg::CCR_I] = 1'b1;
               step_next = 3'h0;
               st_next = cfl_pkg::S_VEC;
            end
         end
         cfl_pkg::S_VEC: begin
            step_next = 3'h1;
            if (step_reg == 3'h0)
               pc_next[15:8] = mem_rdata;
            else begin
               pc_next[7:0] = mem_rdata;
               fin = 1'b1;
            end
         end
         cfl_pkg::S_PULL: begin
            sp_next = sp_reg + 16'h0001;
            step_next = step_reg + 3'h1;
            case (step_reg)
               3'h0:    ccr_next = mem_rdata | cfl_pkg::CCR_FIXED_ONES;
               3'h1:    a_next = mem_rdata;
               3'h2:    x_next = mem_rdata;
               3'h3:    pc_next[15:8] = mem_rdata;
               default: begin
                  pc_next[7:0] = mem_rdata;
                  if (brk_reg & ~break_req)
                     brk_next = 1'b0;
                  fin = 1'b1;
               end
            endcase
         end
         cfl_pkg::S_WAIT: begin
            if (irq_any) begin
               st_next = cfl_pkg::S_PUSH;
               step_next = 3'h0;
               vec_next = cfl_pkg::VEC_IRQ;
            end
         end
         cfl_pkg::S_STOP: begin
            rec_next = 16'h0000;
            if (ext_lvl_reg)
               st_next = cfl_pkg::S_RECOV;
         end
         cfl_pkg::S_RECOV: begin
            rec_next = rec_reg + 16'h0001;
            if (rec_reg >= rec_last) begin
               st_next = cfl_pkg::S_PUSH;
               step_next = 3'h0;
               vec_next = cfl_pkg::VEC_IRQ;
            end
         end
         default: st_next = cfl_pkg::S_FETCH;
      endcase
      if (fin) begin
         step_next = 3'h0;
         if (take_brk) begin
            st_next = cfl_pkg::S_PUSH;
            ir_next = cfl_pkg::OP_TRAP;
            vec_next = trap_vec;
            brk_next = 1'b1;
         end else if (take_irq) begin
            st_next = cfl_pkg::S_PUSH;
            vec_next = cfl_pkg::VEC_IRQ;
         end else
            st_next = cfl_pkg::S_FETCH;
      end
   end

   // =====================================================================
   // state registers
   always_ff @(posedge core_clk) begin
      s1_reg <= ext_irq_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (sys_rst) begin
         st_reg <= cfl_pkg::S_VEC;
         vec_reg <= cfl_pkg::VEC_RESET;
         ccr_reg <= cfl_pkg::CCR_RESET;
         sp_reg <= cfl_pkg::SP_RESET;
         pc_reg <= cfl_pkg::PC_RESET;
         {a_reg, x_reg, h_reg, ir_reg, res_reg} <= 40'h00_0000_0000;
         {ea_reg, rec_reg} <= 32'h0000_0000;
         step_reg <= 3'h0;
         {spm_reg, brk_reg, ext_lvl_reg} <= 3'h0;
      end else begin
         st_reg <= st_next;
         vec_reg <= vec_next;
         ccr_reg <= ccr_next;
         sp_reg <= sp_next;
         pc_reg <= pc_next;
         {a_reg, x_reg, h_reg, ir_reg, res_reg} <= {a_next, x_next, h_next, ir_next, res_next};
         {ea_reg, rec_reg} <= {ea_next, rec_next};
         step_reg <= step_next;
         {spm_reg, brk_reg} <= {spm_next, brk_next};
         if (s2_reg == s3_reg)
            ext_lvl_reg <= s3_reg;
      end
   end
endmodule

// ### bench/cfl_mem_model.sv
// zero-wait byte memory standing on the core's bus
`timescale 1ns/1ps
module cfl_mem_model (
   input  wire logic        core_clk,   // bus clock
   input  wire logic [15:0] mem_addr,   // byte address
   input  wire logic [7:0]  mem_wdata,  // write data
   input  wire logic        mem_we,     // write strobe
   output logic [7:0]       mem_rdata   // read data, same cycle
);
   logic [7:0] mem [0:65535];
   // unused space holds the trap opcode, so a stray fetch shows up on the stack
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = cfl_pkg::OP_TRAP;
      end
   end
   assign mem_rdata = mem[mem_addr];
   always @(posedge core_clk) begin
      if (mem_we) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule

// ### bench/cfl_core_sva.sv
// port assertions for the flag, low-power and break core
`timescale 1ns/1ps
module cfl_core_sva #(
   parameter int OSC_STAB = 8
) (
   input wire logic        core_clk,      // bus clock
   input wire logic        sys_rst,       // synchronous reset
   input wire logic [15:0] mem_addr,      // bus address
   input wire logic [7:0]  mem_rdata,     // read data
   input wire logic [7:0]  mem_wdata,     // write data
   input wire logic        mem_we,        // write strobe
   input wire logic        irq_req,       // maskable request
   input wire logic        ext_irq_pin,   // external pin
   input wire logic        break_req,     // break request
   input wire logic        monitor_mode,  // monitor mode
   input wire logic        core_clk_en,   // core running
   input wire logic        break_active,  // break in progress
   input wire logic        int_mask       // interrupt mask
);
   logic        stop_reg;
   logic        wait_reg;
   logic [15:0] pin_cnt;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // =====================================================================
   // which low-power mode the core entered, and how long the wake pin is held
   always_ff @(posedge core_clk) begin
      if (sys_rst || core_clk_en) begin
         stop_reg <= 1'b0;
         wait_reg <= 1'b0;
      end else if ($past(core_clk_en)) begin
         stop_reg <= $past(mem_rdata) == cfl_pkg::OP_STOP;
         wait_reg <= $past(mem_rdata) == cfl_pkg::OP_WAIT;
      end
   end
   always_ff @(posedge core_clk) begin
      if (stop_reg && ext_irq_pin) pin_cnt <= pin_cnt + 16'h0001;
      else pin_cnt <= 16'h0000;
   end
   // =====================================================================
   a_break_vector: assert property (
      $rose(break_active) |-> mem_we [*5] ##1 mem_addr == (monitor_mode ?
      cfl_pkg::VEC_TRAP_MON : cfl_pkg::VEC_TRAP) ##1 mem_addr[0] == 1'b1)
      else $error("break vector fetch wrong");
   a_break_mask: assert property ($rose(break_active) |-> ##5 int_mask)
      else $error("mask not set after break push");
   a_push_descend: assert property (
      $rose(break_active) ##1 mem_we |-> mem_addr == $past(mem_addr) - 16'h0001)
      else $error("push address not descending");
   a_break_release: assert property ($fell(break_active) |-> !$past(break_req))
      else $error("break ended while still requested");
   a_sleep_mask: assert property ($fell(core_clk_en) |-> !int_mask)
      else $error("mask not cleared on low-power entry");
   a_wait_wake: assert property (
      wait_reg && !core_clk_en && irq_req |-> ##[1:2] core_clk_en)
      else $error("wait not left on request");
   a_stop_delay: assert property (
      $rose(core_clk_en) && stop_reg |-> pin_cnt >= OSC_STAB && pin_cnt <= OSC_STAB + 6)
      else $error("stop recovery length wrong");
   a_stop_bound: assert property (stop_reg |-> pin_cnt <= OSC_STAB + 8)
      else $error("stop never left");
   a_irq_gate: assert property (
      $rose(mem_addr == cfl_pkg::VEC_IRQ) |-> $past(int_mask, 6) == 1'b0)
      else $error("interrupt taken while masked");
   a_reset_mask: assert property (
      $fell(sys_rst) |-> int_mask && mem_addr == cfl_pkg::VEC_RESET)
      else $error("mask or vector wrong after reset");
endmodule
bind cfl_core cfl_core_sva #(.OSC_STAB(OSC_STAB)) u_sva (.core_clk(core_clk), .sys_rst(sys_rst),
   .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we),
   .irq_req(irq_req), .ext_irq_pin(ext_irq_pin), .break_req(break_req),
   .monitor_mode(monitor_mode), .core_clk_en(core_clk_en), .break_active(break_active),
   .int_mask(int_mask));

// ### bench/tb.sv
// self-checking bench for the flag, low-power and break core
`timescale 1ns/1ps
module tb;
   localparam int STAB = 8;
   logic        core_clk;
   logic        sys_rst;
   logic [15:0] mem_addr;
   logic [7:0]  mem_rdata;
   logic [7:0]  mem_wdata;
   logic        mem_we;
   logic        irq_req;
   logic        ext_irq_pin;
   logic        break_req;
   logic        monitor_mode;
   logic        core_clk_en;
   logic        break_active;
   logic        int_mask;
   int          mismatches;
   int          compares;
   int          cyc;
   cfl_core #(.OSC_STAB(STAB)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we), .irq_req(irq_req),
      .ext_irq_pin(ext_irq_pin), .break_req(break_req), .monitor_mode(monitor_mode),
      .core_clk_en(core_clk_en), .break_active(break_active), .int_mask(int_mask));
   cfl_mem_model mem_i (.core_clk(core_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_we(mem_we), .mem_rdata(mem_rdata));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // =====================================================================
   // helpers
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic step();
      @(negedge core_clk);
      cyc++;
   endtask
   // program at 0100, reset for 6 cycles; cyc counts cycles from release
   task automatic load_run(input logic [7:0] code[$]);
      sys_rst = 1'b1;
      for (int i = 0; i < code.size(); i++) mem_i.mem[16'h0100 + i] = code[i];
      repeat (6) @(negedge core_clk);
      sys_rst = 1'b0;
      cyc = 0;
   endtask
   task automatic wait_we(output int at);
      int n;
      n = 0;
      while (mem_we !== 1'b1 && n < 300) begin
         step();
         n++;
      end
      at = cyc;
   endtask
   task automatic chk_stack(input logic [15:0] sp, input logic [15:0] pc, input logic [7:0] x,
                            input logic [7:0] a, input logic [7:0] ccr);
      check("stacked pc", {mem_i.mem[sp - 16'h0001], mem_i.mem[sp]}, pc);
      check("stacked x", {8'h00, mem_i.mem[sp - 16'h0002]}, {8'h00, x});
      check("stacked a", {8'h00, mem_i.mem[sp - 16'h0003]}, {8'h00, a});
      check("stacked ccr", {8'h00, mem_i.mem[sp - 16'h0004]}, {8'h00, ccr});
   endtask
   // runs to the closing trap, then judges its cycle and the stacked state
   task automatic run_prog(input logic [7:0] code[$], input int exp_at, input logic [15:0] sp,
                           input logic [15:0] pc, input logic [7:0] x, input logic [7:0] a,
                           input logic [7:0] ccr);
      int at;
      load_run(code);
      wait_we(at);
      check("first write cycle", 16'(at), 16'(exp_at));
      repeat (12) step();
      chk_stack(sp, pc, x, a, ccr);
   endtask
   // =====================================================================
   // scenarios
   task automatic t_alu();
      run_prog('{8'hAB, 8'hFF, 8'hAB, 8'h01, 8'hA4, 8'h00, 8'h83}, 9, 16'h00FF, 16'h0107, 8'h00,
               8'h00, 8'h7B);
      run_prog('{8'hAB, 8'hFF, 8'hAB, 8'h01, 8'hA9, 8'h05, 8'h83}, 9, 16'h00FF, 16'h0107, 8'h00,
               8'h06, 8'h68);
   endtask
   task automatic t_branch();
      run_prog('{8'hAB, 8'hFF, 8'h24, 8'h02, 8'hAB, 8'h01, 8'h48, 8'h25, 8'h01, 8'h47, 8'h47,
                 8'h24, 8'h01, 8'h83, 8'h25, 8'h7F, 8'h83}, 19, 16'h00FF, 16'h0111, 8'h00,
               8'hFF, 8'hEC);
   endtask
   task automatic t_adjust();
      irq_req = 1'b1;
      run_prog('{8'hAB, 8'h00, 8'hA7, 8'hFE, 8'hAF, 8'h81, 8'h83}, 9, 16'h00FD, 16'h0107, 8'h81,
               8'h00, 8'h6A);
      irq_req = 1'b0;
   endtask
   task automatic t_bitclr();
      int at;
      for (int n = 0; n < 8; n++) begin
         mem_i.mem[16'h0040] = 8'hFF;
         load_run('{8'h11 + 8'(2 * n), 8'h40, 8'h83});
         wait_we(at);
         check("clear cycle", 16'(at), 16'h0005);
         check("clear addr", mem_addr, 16'h0040);
         check("clear data", {8'h00, mem_wdata}, {8'h00, ~(8'h01 << n)});
         repeat (14) step();
         check("clear flags", {8'h00, mem_i.mem[16'h00FB]}, 16'h0068);
      end
   endtask
   task automatic t_memshift();
      mem_i.mem[16'h0040] = 8'h81;
      mem_i.mem[16'h0140] = 8'h80;
      load_run('{8'h38, 8'h40, 8'h77, 8'h9E, 8'h67, 8'h41, 8'h83});
      repeat (20) step();
      check("shift dir", {8'h00, mem_i.mem[16'h0040]}, 16'h0002);
      check("shift ix", {8'h00, mem_i.mem[16'h0000]}, 16'h00C1);
      check("shift sp", {8'h00, mem_i.mem[16'h0140]}, 16'h00C0);
      chk_stack(16'h00FF, 16'h0107, 8'h00, 8'h00, 8'hEC);
   endtask
   task automatic t_lowpower();
      int n;
      load_run('{cfl_pkg::OP_WAIT});
      repeat (4) step();
      check("wait state", {14'h0, core_clk_en, int_mask}, 16'h0000);
      irq_req = 1'b1;
      wait_we(n);
      irq_req = 1'b0;
      repeat (12) step();
      chk_stack(16'h00FF, 16'h0101, 8'h00, 8'h00, 8'h60);
      check("stop state", {14'h0, core_clk_en, int_mask}, 16'h0000);
      ext_irq_pin = 1'b1;
      n = 0;
      while (core_clk_en !== 1'b1 && n < 100) begin
         step();
         n++;
      end
      check("stop recovery", 16'(n >= STAB && n <= STAB + 6), 16'h0001);
      wait_we(n);
      ext_irq_pin = 1'b0;
      repeat (12) step();
      chk_stack(16'h00FA, 16'h0301, 8'h00, 8'h00, 8'h60);
      load_run('{cfl_pkg::OP_WAIT});
      check("mask after reset", {15'h0, int_mask}, 16'h0001);
   endtask
   task automatic t_break();
      for (int m = 0; m < 2; m++) begin
         monitor_mode = m[0];
         load_run('{8'hAB, 8'h01, 8'hAB, 8'h02, 8'hAB, 8'h04, cfl_pkg::OP_WAIT});
         repeat (4 + m) step();
         break_req = 1'b1;
         while (cyc < 6) step();
         check("push start", {mem_we, break_active, mem_addr[13:0]}, 16'hC0FF);
         if (m == 0) break_req = 1'b0;
         repeat (5) step();
         check("vector", mem_addr, (m == 1) ? 16'hFEFC : 16'hFFFC);
         step();
         check("vector low", mem_addr, (m == 1) ? 16'hFEFD : 16'hFFFD);
         check("pushed pc", {mem_i.mem[16'h00FE], mem_i.mem[16'h00FF]}, 16'h0104);
         repeat (30) step();
         check("break end", {14'h0, core_clk_en, break_active}, {15'h0, m[0]});
         break_req = 1'b0;
      end
   endtask
   // =====================================================================
   initial begin
      sys_rst = 1'b1;
      irq_req = 1'b0;
      ext_irq_pin = 1'b0;
      break_req = 1'b0;
      monitor_mode = 1'b0;
      mismatches = 0;
      compares = 0;
      cyc = 0;
      @(negedge core_clk);
      {mem_i.mem[16'hFFFE], mem_i.mem[16'hFFFF]} = 16'h0100;
      {mem_i.mem[16'hFFFC], mem_i.mem[16'hFFFD]} = 16'h0200;
      {mem_i.mem[16'hFFFA], mem_i.mem[16'hFFFB]} = 16'h0300;
      {mem_i.mem[16'hFEFC], mem_i.mem[16'hFEFD]} = 16'h0400;
      mem_i.mem[16'h0200] = cfl_pkg::OP_WAIT;
      mem_i.mem[16'h0300] = cfl_pkg::OP_STOP;
      mem_i.mem[16'h0400] = cfl_pkg::OP_RET_TRAP;
      t_alu();
      t_branch();
      t_adjust();
      t_bitclr();
      t_memshift();
      t_lowpower();
      {mem_i.mem[16'hFFFC], mem_i.mem[16'hFFFD]} = 16'h0400;
      t_break();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      print_verdict();
   end
endmodule
